// ===== verilog/gdpmd_device.sv
`timescale 1ns/1ps
`default_nettype none
// gate driver end: mode decode, commutation, dead time per phase
module gdpmd_device
   import gdpmd_pkg::*;
(
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic variant_strap,
   input wire logic [2:0] mode_strap,
   gdpmd_if.dev bus,
   output logic [2:0] mode_active,
   output logic variant_hw
);

   // strap synchronisers and capture
   logic variant_s1_r;
   logic variant_s2_r;
   logic [2:0] strap_s1_r;
   logic [2:0] strap_s2_r;
   logic [1:0] cap_cnt_r;
   logic variant_r;
   logic [2:0] strap_mode_r;
   logic [2:0] mode_active_r;

   // decode results
   logic [2:0] mode_eff;
   logic [2:0] want_h;
   logic [2:0] want_l;
   logic [2:0] bypass;
   logic [2:0] hi_in;
   logic [2:0] lo_in;
   logic [2:0] sp_code;
   logic [2:0] sp_pwm;
   logic [2:0] sp_hold;
   logic sp_async;
   logic sp_brake;
   logic [2:0] gate_h_w;
   logic [2:0] gate_l_w;

   // strap level to mode; 100b has no strap level
   function automatic logic [2:0] strap_to_mode(input logic [2:0] lvl);
      logic [2:0] m;
      m = GDPMD_M_INDEP;
      unique case (lvl)
         STRAP_GND: m = GDPMD_M_SIX;
         STRAP_18K_GND: m = GDPMD_M_THREE;
         STRAP_75K_GND: m = GDPMD_M_SINGLE;
         STRAP_HIZ: m = GDPMD_M_HB;
         STRAP_75K_VDD: m = GDPMD_M_MIX_A;
         STRAP_18K_VDD: m = GDPMD_M_MIX_BC;
         default: m = GDPMD_M_INDEP;
      endcase
      return m;
   endfunction

   // phases run as independent FETs in a given mode
   function automatic logic [2:0] indep_mask(input logic [2:0] m);
      logic [2:0] k;
      k = 3'h0;
      unique case (m)
         GDPMD_M_MIX_C: k = 3'h4;
         GDPMD_M_MIX_A: k = 3'h1;
         GDPMD_M_MIX_BC: k = 3'h6;
         GDPMD_M_INDEP: k = 3'h7;
         default: k = 3'h0;
      endcase
      return k;
   endfunction

   // half-bridge decode: low input low floats, else high input picks side
   function automatic logic [1:0] hb_decode(input logic h, input logic l);
      return {l & h, l & ~h};
   endfunction

   // two-stage synchronisers on the strap pins
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         variant_s1_r <= 1'b0;
         variant_s2_r <= 1'b0;
         strap_s1_r <= 3'h0;
         strap_s2_r <= 3'h0;
      end else begin
         variant_s1_r <= variant_strap;
         variant_s2_r <= variant_s1_r;
         strap_s1_r <= mode_strap;
         strap_s2_r <= strap_s1_r;
      end
   end

   // capture the straps once, after they cross the synchroniser
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         cap_cnt_r <= 2'h0;
      end else if (cap_cnt_r != STRAP_CAP_CYC + 2'h1) begin
         cap_cnt_r <= cap_cnt_r + 2'h1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         variant_r <= 1'b0;
         strap_mode_r <= GDPMD_M_SIX;
      end else if (cap_cnt_r == STRAP_CAP_CYC) begin
         variant_r <= variant_s2_r;
         strap_mode_r <= strap_to_mode(strap_s2_r);
      end
   end

   // effective mode: strap in hardware variant, mode field otherwise
   assign mode_eff = variant_r ? strap_mode_r : bus.mode_sel;

   assign hi_in = bus.high_side_input;
   assign lo_in = bus.low_side_input;

   // async freewheeling and stop choice exist only in the serial variant
   assign sp_async = ~variant_r & bus.single_pwm_async_sel;
   assign sp_brake = variant_r | bus.single_pwm_stop_sel;

   // single-PWM state code, complemented when direction is high, except the stop and align codes
   always_comb begin
      sp_code = {lo_in[PH_A], hi_in[PH_B], lo_in[PH_B]};
      if (hi_in[PH_C] && sp_code != SP_STOP && sp_code != SP_ALIGN) begin
         sp_code = ~sp_code;
      end
   end

   // commutation table: PWM phase and held low phases
   always_comb begin
      sp_pwm = 3'h0;
      sp_hold = 3'h0;
      unique case (sp_code)
         SP_STOP: begin
            sp_pwm = 3'h0;
            sp_hold = 3'h0;
         end
         SP_ALIGN: begin
            sp_pwm = 3'h1;
            sp_hold = 3'h6;
         end
         SP_B_TO_C: begin
            sp_pwm = 3'h2;
            sp_hold = 3'h4;
         end
         SP_A_TO_C: begin
            sp_pwm = 3'h1;
            sp_hold = 3'h4;
         end
         SP_A_TO_B: begin
            sp_pwm = 3'h1;
            sp_hold = 3'h2;
         end
         SP_C_TO_B: begin
            sp_pwm = 3'h4;
            sp_hold = 3'h2;
         end
         SP_C_TO_A: begin
            sp_pwm = 3'h4;
            sp_hold = 3'h1;
         end
         SP_B_TO_A: begin
            sp_pwm = 3'h2;
            sp_hold = 3'h1;
         end
      endcase
   end

   // per-mode gate request decode
   always_comb begin
      want_h = 3'h0;
      want_l = 3'h0;
      bypass = indep_mask(mode_eff);
      unique case (mode_eff)
         GDPMD_M_SIX: begin
            want_h = hi_in & ~lo_in;
            want_l = lo_in & ~hi_in;
         end
         GDPMD_M_SINGLE: begin
            if (!lo_in[PH_C]) begin
               // brake wins over every other input, or coasts
               want_h = 3'h0;
               want_l = sp_brake ? 3'h7 : 3'h0;
            end else begin
               for (int i = 0; i < 3; i++) begin
                  want_h[i] = sp_pwm[i] & hi_in[PH_A];
                  want_l[i] = sp_hold[i] | (sp_pwm[i] & ~hi_in[PH_A] & ~sp_async);
               end
            end
         end
         GDPMD_M_THREE, GDPMD_M_HB, GDPMD_M_MIX_C, GDPMD_M_MIX_A, GDPMD_M_MIX_BC,
         GDPMD_M_INDEP: begin
            for (int i = 0; i < 3; i++) begin
               if (bypass[i]) begin
                  want_h[i] = hi_in[i];
                  want_l[i] = lo_in[i];
               end else begin
                  {want_h[i], want_l[i]} = hb_decode(hi_in[i], lo_in[i]);
               end
            end
         end
      endcase
   end

   // one dead-time stage per phase, also the output register
   for (genvar p = 0; p < 3; p++) begin : g_phase
      gdpmd_deadtime u_dt (
         .clk_sys(clk_sys),
         .srst(srst),
         .want_h(want_h[p]),
         .want_l(want_l[p]),
         .bypass(bypass[p]),
         .gate_h(gate_h_w[p]),
         .gate_l(gate_l_w[p])
      );
   end

   // mode status register
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         mode_active_r <= GDPMD_M_SIX;
      end else begin
         mode_active_r <= mode_eff;
      end
   end

   assign bus.high_gate_out = gate_h_w;
   assign bus.low_gate_out = gate_l_w;
   assign mode_active = mode_active_r;
   assign variant_hw = variant_r;

endmodule
`default_nettype wire

// ===== verilog/gdpmd_pkg.sv
package gdpmd_pkg;

   // device clock
   localparam int CLK_PERIOD_NS = 20;

   // dead time inserted between opposite gates of a half-bridge
   localparam int DEAD_NS = 100;
   localparam logic [3:0] DEAD_CYC = 4'((DEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

   // ready time after enable before the controller acts
   localparam int READY_NS = 1000000;
   localparam int READY_CYC_DEF = READY_NS / CLK_PERIOD_NS;

   // quiet time with all inputs low around a mode change
   localparam int QUIET_NS = 200;
   localparam logic [3:0] QUIET_CYC = 4'(QUIET_NS / CLK_PERIOD_NS);

   // strap capture delay after reset release (synchroniser depth)
   localparam logic [1:0] STRAP_CAP_CYC = 2'h2;

   // reset values
   localparam logic [2:0] GATE_RST = 3'h0;

   // phase indices
   localparam int PH_A = 0;
   localparam int PH_B = 1;
   localparam int PH_C = 2;

   // control modes
   typedef enum logic [2:0] {
      GDPMD_M_SIX = 3'h0,
      GDPMD_M_THREE = 3'h1,
      GDPMD_M_SINGLE = 3'h2,
      GDPMD_M_HB = 3'h3,
      GDPMD_M_MIX_C = 3'h4,
      GDPMD_M_MIX_A = 3'h5,
      GDPMD_M_MIX_BC = 3'h6,
      GDPMD_M_INDEP = 3'h7
   } gdpmd_mode_t;

   // strap levels, low to high on the resistor ladder
   localparam logic [2:0] STRAP_GND = 3'h0;
   localparam logic [2:0] STRAP_18K_GND = 3'h1;
   localparam logic [2:0] STRAP_75K_GND = 3'h2;
   localparam logic [2:0] STRAP_HIZ = 3'h3;
   localparam logic [2:0] STRAP_75K_VDD = 3'h4;
   localparam logic [2:0] STRAP_18K_VDD = 3'h5;

   // single-PWM state codes {state2,state1,state0}, direction low
   localparam logic [2:0] SP_STOP = 3'h0;
   localparam logic [2:0] SP_ALIGN = 3'h7;
   localparam logic [2:0] SP_B_TO_C = 3'h6;
   localparam logic [2:0] SP_A_TO_C = 3'h4;
   localparam logic [2:0] SP_A_TO_B = 3'h5;
   localparam logic [2:0] SP_C_TO_B = 3'h1;
   localparam logic [2:0] SP_C_TO_A = 3'h3;
   localparam logic [2:0] SP_B_TO_A = 3'h2;

   // host sequencer states
   typedef enum logic [1:0] {
      GDPMD_H_WAIT = 2'h0,
      GDPMD_H_RUN = 2'h1,
      GDPMD_H_QUIET = 2'h2
   } gdpmd_hstate_t;

endpackage

// ===== verilog/gdpmd_if.sv
`timescale 1ns/1ps
`default_nettype none
// control pins from controller to gate driver, gate commands back
interface gdpmd_if;
   logic [2:0] high_side_input;
   logic [2:0] low_side_input;
   logic [2:0] mode_sel;
   logic single_pwm_async_sel;
   logic single_pwm_stop_sel;
   logic [2:0] high_gate_out;
   logic [2:0] low_gate_out;

   modport dev (
      input high_side_input,
      input low_side_input,
      input mode_sel,
      input single_pwm_async_sel,
      input single_pwm_stop_sel,
      output high_gate_out,
      output low_gate_out
   );

   modport host (
      output high_side_input,
      output low_side_input,
      output mode_sel,
      output single_pwm_async_sel,
      output single_pwm_stop_sel,
      input high_gate_out,
      input low_gate_out
   );
endinterface
`default_nettype wire

// ===== verilog/gdpmd_deadtime.sv
`timescale 1ns/1ps
`default_nettype none
// one phase: registers the gate pair, optional dead time on turn-on
module gdpmd_deadtime
   import gdpmd_pkg::*;
(
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic want_h,
   input wire logic want_l,
   input wire logic bypass,
   output logic gate_h,
   output logic gate_l
);

   logic gate_h_r;
   logic gate_l_r;
   logic [3:0] off_cnt_r;
   logic gate_h_nxt;
   logic gate_l_nxt;
   logic gap_ok;

   // a side may turn on once the pair has been off for the dead time
   assign gap_ok = (off_cnt_r == DEAD_CYC);

   always_comb begin
      if (bypass) begin
         gate_h_nxt = want_h;
         gate_l_nxt = want_l;
      end else begin
         // never both, turn-off at once, turn-on after the gap
         gate_h_nxt = want_h & ~want_l & ~gate_l_r & (gate_h_r | gap_ok);
         gate_l_nxt = want_l & ~want_h & ~gate_h_r & (gate_l_r | gap_ok);
      end
   end

   // gate command registers
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         gate_h_r <= 1'b0;
         gate_l_r <= 1'b0;
      end else begin
         gate_h_r <= gate_h_nxt;
         gate_l_r <= gate_l_nxt;
      end
   end

   // cycles since both gates went off, saturating
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         off_cnt_r <= DEAD_CYC;
      end else if (gate_h_r | gate_l_r) begin
         off_cnt_r <= 4'h1;
      end else if (!gap_ok) begin
         off_cnt_r <= off_cnt_r + 4'h1;
      end
   end

   assign gate_h = gate_h_r;
   assign gate_l = gate_l_r;

endmodule
`default_nettype wire

// ===== verilog/gdpmd_host.sv
`timescale 1ns/1ps
`default_nettype none
// controller end: ready wait, quiet mode changes, pin conditioning
module gdpmd_host
   import gdpmd_pkg::*;
#(
   parameter int READY_CYC = READY_CYC_DEF
)
(
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic [2:0] usr_mode,
   input wire logic usr_mode_req,
   input wire logic [2:0] usr_high,
   input wire logic [2:0] usr_low,
   input wire logic usr_async,
   input wire logic usr_brake_stop,
   input wire logic usr_float_used,
   input wire logic usr_dir_used,
   input wire logic usr_brake_used,
   gdpmd_if.host bus,
   output logic host_ready,
   output logic mode_busy
);

   gdpmd_hstate_t state_r;
   logic [31:0] rdy_cnt_r;
   logic [3:0] quiet_cnt_r;
   logic [2:0] mode_r;
   logic [2:0] pend_r;
   logic [2:0] high_r;
   logic [2:0] low_r;
   logic async_r;
   logic stop_r;
   logic ready_r;
   logic busy_r;
   logic [2:0] high_nxt;
   logic [2:0] low_nxt;

   // sequencer: wait ready time, then run; mode change goes via quiet
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         state_r <= GDPMD_H_WAIT;
         rdy_cnt_r <= 32'h0;
         quiet_cnt_r <= 4'h0;
         mode_r <= GDPMD_M_SIX;
         pend_r <= GDPMD_M_SIX;
      end else begin
         unique case (state_r)
            GDPMD_H_WAIT: begin
               if (rdy_cnt_r == 32'(READY_CYC) - 32'h1) begin
                  state_r <= GDPMD_H_RUN;
               end
               rdy_cnt_r <= rdy_cnt_r + 32'h1;
            end
            GDPMD_H_RUN: begin
               if (usr_mode_req && usr_mode != mode_r) begin
                  pend_r <= usr_mode;
                  quiet_cnt_r <= 4'h0;
                  state_r <= GDPMD_H_QUIET;
               end
            end
            GDPMD_H_QUIET: begin
               quiet_cnt_r <= quiet_cnt_r + 4'h1;
               if (quiet_cnt_r == QUIET_CYC - 4'h1) begin
                  mode_r <= pend_r;
               end
               if (quiet_cnt_r == QUIET_CYC) begin
                  state_r <= GDPMD_H_RUN;
               end
            end
            default: state_r <= GDPMD_H_WAIT;
         endcase
      end
   end

   // pin values from user requests, conditioned per mode
   always_comb begin
      high_nxt = usr_high;
      low_nxt = usr_low;
      if (mode_r == GDPMD_M_THREE && !usr_float_used) begin
         low_nxt = 3'h7;
      end
      if (mode_r == GDPMD_M_SINGLE && !usr_dir_used) begin
         high_nxt[PH_C] = 1'b0;
      end
      if (mode_r == GDPMD_M_SINGLE && !usr_brake_used) begin
         low_nxt[PH_C] = 1'b1;
      end
      if (state_r != GDPMD_H_RUN) begin
         high_nxt = 3'h0;
         low_nxt = 3'h0;
      end
   end

   // pin and status registers
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         high_r <= 3'h0;
         low_r <= 3'h0;
         async_r <= 1'b0;
         stop_r <= 1'b1;
         ready_r <= 1'b0;
         busy_r <= 1'b1;
      end else begin
         high_r <= high_nxt;
         low_r <= low_nxt;
         async_r <= usr_async;
         stop_r <= usr_brake_stop;
         ready_r <= (state_r != GDPMD_H_WAIT);
         busy_r <= (state_r != GDPMD_H_RUN);
      end
   end

   assign bus.high_side_input = high_r;
   assign bus.low_side_input = low_r;
   assign bus.mode_sel = mode_r;
   assign bus.single_pwm_async_sel = async_r;
   assign bus.single_pwm_stop_sel = stop_r;
   assign host_ready = ready_r;
   assign mode_busy = busy_r;

endmodule
`default_nettype wire

// ===== bench/gdpmd_props.sv
`timescale 1ns/1ps
`default_nettype none
// watches the link between controller end and gate driver end
module gdpmd_props
   import gdpmd_pkg::*;
(
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic [2:0] high_side_input,
   input wire logic [2:0] low_side_input,
   input wire logic [2:0] mode_sel,
   input wire logic single_pwm_async_sel,
   input wire logic single_pwm_stop_sel,
   input wire logic [2:0] high_gate_out,
   input wire logic [2:0] low_gate_out
);
   default clocking @(posedge clk_sys);
   endclocking
   default disable iff (srst);
   logic [2:0] hb_mask;
   logic [2:0] h_only;
   // phases run as half-bridges in the current mode
   assign hb_mask = (mode_sel == 3'h4) ? 3'h3 : (mode_sel == 3'h5) ? 3'h6 :
      (mode_sel == 3'h6) ? 3'h1 : (mode_sel == 3'h7) ? 3'h0 : 3'h7;
   assign h_only = high_side_input & ~low_side_input;
   property p_no_shoot;
      (high_gate_out & low_gate_out & hb_mask) == 3'h0;
   endproperty
   a_no_shoot: assert property (p_no_shoot) else $error("gates on together");
   property p_indep;
      mode_sel == 3'h7 && $stable(mode_sel) |=> high_gate_out == $past(high_side_input)
         && low_gate_out == $past(low_side_input);
   endproperty
   a_indep: assert property (p_indep) else $error("direct drive wrong");
   property p_six_off;
      mode_sel == 3'h0 && $stable(mode_sel) |=> (high_gate_out & ~$past(h_only)) == 3'h0
         && (low_gate_out & ~$past(low_side_input & ~high_side_input)) == 3'h0;
   endproperty
   a_six_off: assert property (p_six_off) else $error("six input gate wrong");
   property p_six_on;
      (mode_sel == 3'h0 && h_only[0])[*8] |-> high_gate_out[0];
   endproperty
   a_six_on: assert property (p_six_on) else $error("high gate late");
   property p_float;
      (mode_sel == 3'h1 || mode_sel == 3'h3) && $stable(mode_sel) |=>
         ((high_gate_out | low_gate_out) & ~$past(low_side_input)) == 3'h0
         && (high_gate_out & ~$past(high_side_input)) == 3'h0;
   endproperty
   a_float: assert property (p_float) else $error("float decode wrong");
   property p_brake;
      (mode_sel == 3'h2 && !low_side_input[2] && single_pwm_stop_sel)[*8] |->
         high_gate_out == 3'h0 && low_gate_out == 3'h7;
   endproperty
   a_brake: assert property (p_brake) else $error("brake wrong");
   property p_coast;
      mode_sel == 3'h2 && $stable(mode_sel) && !low_side_input[2] && !single_pwm_stop_sel
         |=> high_gate_out == 3'h0 && low_gate_out == 3'h0;
   endproperty
   a_coast: assert property (p_coast) else $error("coast wrong");
   property p_sp_pwm;
      mode_sel == 3'h2 && $stable(mode_sel) |=> $onehot0(high_gate_out)
         && (high_gate_out == 3'h0 || $past(high_side_input[0]));
   endproperty
   a_sp_pwm: assert property (p_sp_pwm) else $error("pwm gate wrong");
   property p_quiet;
      $changed(mode_sel) |-> high_side_input == 3'h0 && low_side_input == 3'h0
         && $past(high_side_input, 8) == 3'h0 && $past(low_side_input, 8) == 3'h0;
   endproperty
   a_quiet: assert property (p_quiet) else $error("mode change not quiet");
   // main scenarios reached
   c_brake: cover property (mode_sel == 3'h2 && low_gate_out == 3'h7);
   c_change: cover property ($changed(mode_sel));
   c_both_on: cover property (mode_sel == 3'h7 && (high_gate_out & low_gate_out) != 3'h0);
   c_async: cover property (mode_sel == 3'h2 && single_pwm_async_sel);
endmodule
`default_nettype wire

// ===== bench/tb_gate_drive_pwm_mode_decoder.sv
`timescale 1ns/1ps
`default_nettype none
// both link ends driven from the controller user side
module tb_gate_drive_pwm_mode_decoder
   import gdpmd_pkg::*;
;
   localparam int RDY = 20;
   localparam logic [15:0] P_TAB = 16'h1098; // pwm phase by state code
   localparam logic [23:0] Q_TAB = 24'hD14250; // held low gates by state code
   logic clk_sys = 1'b0;
   logic srst = 1'b1;
   logic [2:0] usr_mode = 3'h0;
   logic usr_mode_req = 1'b0;
   logic [2:0] usr_high = 3'h0;
   logic [2:0] usr_low = 3'h0;
   logic usr_async = 1'b0;
   logic usr_brake_stop = 1'b1;
   logic usr_float_used = 1'b1;
   logic usr_dir_used = 1'b1;
   logic usr_brake_used = 1'b1;
   logic variant_strap = 1'b0;
   logic [2:0] mode_strap = 3'h0;
   logic [2:0] mode_active;
   logic variant_hw;
   logic host_ready;
   logic mode_busy;
   int n_mismatch = 0;
   int checks = 0;
   gdpmd_if bus ();
   gdpmd_host #(.READY_CYC(RDY)) u_gdpmd_host (.clk_sys, .srst, .usr_mode, .usr_mode_req,
      .usr_high, .usr_low, .usr_async, .usr_brake_stop, .usr_float_used, .usr_dir_used,
      .usr_brake_used, .bus(bus), .host_ready, .mode_busy);
   gdpmd_device u_gdpmd_device (.clk_sys, .srst, .variant_strap, .mode_strap,
      .bus(bus), .mode_active, .variant_hw);
   gdpmd_props u_gdpmd_props (.clk_sys, .srst, .high_side_input(bus.high_side_input),
      .low_side_input(bus.low_side_input), .mode_sel(bus.mode_sel),
      .single_pwm_async_sel(bus.single_pwm_async_sel),
      .single_pwm_stop_sel(bus.single_pwm_stop_sel),
      .high_gate_out(bus.high_gate_out), .low_gate_out(bus.low_gate_out));
   // 50 MHz clock
   always #10 clk_sys = ~clk_sys;
   task automatic tick;
      @(posedge clk_sys);
      #1;
   endtask
   task automatic chk(input logic [5:0] got, input logic [5:0] exp);
      checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic end_of_test;
      if (n_mismatch == 0 && checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // request a mode and wait out the quiet phase
   task automatic set_mode(input logic [2:0] m);
      int n;
      n = 0;
      usr_high = 3'h0;
      usr_low = 3'h0;
      usr_mode = m;
      usr_mode_req = 1'b1;
      tick;
      usr_mode_req = 1'b0;
      repeat (2) tick;
      while (mode_busy !== 1'b0 && n < 40) begin
         tick;
         n++;
      end
      chk({5'h0, mode_busy}, 6'h0);
      chk({3'h0, bus.mode_sel}, {3'h0, m});
      chk({2'h0, variant_hw, mode_active}, {3'h0, m});
   endtask
   // strap level to expected mode, 100b has no level
   function automatic logic [2:0] exp_strap(input logic [2:0] lvl);
      logic [2:0] r;
      r = (lvl > 3'h5) ? 3'h7 : (lvl > 3'h3) ? lvl + 3'h1 : lvl;
      return r;
   endfunction
   // settled gate pattern for a mode and pin set
   function automatic logic [5:0] exp_gates(input logic [2:0] m, input logic [2:0] h,
         input logic [2:0] l, input logic as, input logic st);
      logic [2:0] ind;
      logic [2:0] gh;
      logic [2:0] gl;
      logic [2:0] c;
      logic [1:0] p;
      ind = (m == 3'h4) ? 3'h4 : (m == 3'h5) ? 3'h1 : (m == 3'h6) ? 3'h6 : {3{m == 3'h7}};
      gh = (ind & h) | (~ind & l & h);
      gl = (ind & l) | (~ind & l & ~h);
      if (m == 3'h0) begin
         gh = h & ~l;
         gl = l & ~h;
      end
      if (m == 3'h2) begin
         c = {l[0], h[1], l[1]};
         if (h[2] && c != 3'h0 && c != 3'h7) begin
            c = ~c;
         end
         p = P_TAB[c*2 +: 2];
         gh = (c == 3'h0) ? 3'h0 : {2'h0, h[0]} << p;
         gl = (c == 3'h0) ? 3'h0 : Q_TAB[c*3 +: 3] | ((h[0] | as) ? 3'h0 : 3'h1 << p);
         if (!l[2]) begin
            gh = 3'h0;
            gl = {3{st}};
         end
      end
      return {gh, gl};
   endfunction
   // hang guard
   initial begin
      #(20 * 30000);
      n_mismatch++;
      end_of_test;
   end
   // main sequence
   initial begin
      int i;
      int m;
      int n;
      logic [2:0] h;
      logic [2:0] l;
      logic a;
      logic s;
      i = $urandom(57);
      repeat (10) tick;
      srst = 1'b0;
      usr_mode = 3'h3;
      usr_mode_req = 1'b1;
      tick;
      usr_mode_req = 1'b0;
      repeat (RDY - 3) tick;
      chk({5'h0, host_ready}, 6'h0);
      n = 0;
      while (host_ready !== 1'b1 && n < 40) begin
         tick;
         n++;
      end
      chk({5'h0, host_ready}, 6'h1);
      chk({3'h0, bus.mode_sel}, 6'h0);
      for (m = 0; m < 8; m++) begin
         set_mode(3'(m));
         for (i = 0; i < 80; i++) begin
            if (m == 2 && i < 64) begin
               h = {i[4], i[1], i[5]};
               l = {1'b1, i[2], i[0]};
               a = i[3];
               s = 1'b1;
            end else begin
               {h, l, a, s} = 8'($urandom);
            end
            usr_high = h;
            usr_low = l;
            usr_async = a;
            usr_brake_stop = s;
            repeat (10) tick;
            chk({bus.high_gate_out, bus.low_gate_out}, exp_gates(3'(m), h, l, a, s));
         end
      end
      usr_mode_req = 1'b1;
      tick;
      usr_mode_req = 1'b0;
      tick;
      chk({5'h0, mode_busy}, 6'h0);
      set_mode(3'h1);
      usr_float_used = 1'b0;
      usr_high = 3'h5;
      repeat (10) tick;
      chk({bus.low_side_input, bus.high_gate_out}, 6'h3D);
      usr_float_used = 1'b1;
      set_mode(3'h2);
      usr_dir_used = 1'b0;
      usr_brake_used = 1'b0;
      usr_high = 3'h4;
      repeat (3) tick;
      chk({4'h0, bus.high_side_input[2], bus.low_side_input[2]}, 6'h01);
      // strapped variant: mode captured from the strap level after reset
      for (i = 0; i < 8; i++) begin
         srst = 1'b1;
         variant_strap = 1'b1;
         mode_strap = 3'(i);
         repeat (2) tick;
         srst = 1'b0;
         repeat (4) tick;
         chk({2'h0, variant_hw, mode_active}, {3'h1, exp_strap(3'(i))});
      end
      srst = 1'b1;
      tick;
      end_of_test;
   end
endmodule
`default_nettype wire
